// [src/ect_clkgen.sv]
/*
  Counter clock source: a free prescaler, selection of one of six divided
  clocks or the external clock, and an edge detector yielding tick pulses.
  Assumes ext_clock_input is synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ect_clkgen
  import ect_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       hold,
  input  wire logic [2:0] clock_select,
  input  wire logic       internal_clock_select,
  input  wire logic       ext_clock_input,
  output logic            tick
);

  logic [PRESC_W-1:0] presc_q;
  logic               lvl_q;
  logic               div_lvl;
  logic               src_lvl;
  logic               both_edges;

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  // Divided clocks /4../128; a falling edge of the level counts
  assign div_lvl = (clock_select == CKS_DIV_LO)  ? presc_q[{2'h0, internal_clock_select} + 3'h1] :
                   (clock_select == CKS_DIV_MID) ? presc_q[{2'h0, internal_clock_select} + 3'h3] :
                   (clock_select == CKS_DIV_HI)  ? presc_q[{2'h0, internal_clock_select} + 3'h5] :
                   1'b0;
  // Rising edges are counted as falling edges of the inverted pin
  assign src_lvl = (clock_select == CKS_EXT_R) ? ~ext_clock_input :
                   (clock_select == CKS_EXT_F || clock_select == CKS_EXT_B) ? ext_clock_input :
                   div_lvl;
  assign both_edges = (clock_select == CKS_EXT_B);

  // A switch of source is seen like any edge of the merged level
  assign tick = both_edges ? (lvl_q ^ src_lvl) : (lvl_q & ~src_lvl);

  // ----------------------------------------------------------------------
  // Prescaler and level history
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
      lvl_q   <= 1'b0;
    end else if (hold) begin
      presc_q <= '0;
      lvl_q   <= 1'b0;
    end else begin
      presc_q <= presc_q + 1'b1;
      lvl_q   <= src_lvl;
    end
  end

endmodule
`default_nettype wire

// [src/ect_irq.sv]
/*
  Sticky interrupt flags with write-one-to-clear and enable gating onto one
  level request. Assumes set and clear strobes are single-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module ect_irq
  import ect_pkg::*;
#(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         hold,
  input  wire logic [N-1:0] set_ev,
  input  wire logic [N-1:0] clr_ev,
  input  wire logic [N-1:0] enable,
  output logic [N-1:0]      flags_q,
  output logic              irq
);

  logic [N-1:0] flags_d;

  // ----------------------------------------------------------------------
  // Flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  assign flags_d = hold ? '0 : ((flags_q & ~clr_ev) | set_ev);
  assign irq     = |(flags_q & enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (!hold && set_ev != '0) |=> ((flags_q & $past(set_ev)) == $past(set_ev)))
    else $error("event flag not latched");

endmodule
`default_nettype wire

// [src/ect_pkg.sv]
/*
  Shared constants of the eight-bit compare timer: register offsets, field
  positions, reset values, clock-select codes and output actions.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package ect_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL0  = 8'h00;  // control_reg_zero
  localparam logic [7:0] OFF_CTRL1  = 8'h04;  // control_reg_one
  localparam logic [7:0] OFF_CSR    = 8'h08;  // control_status_reg
  localparam logic [7:0] OFF_CONSTA = 8'h0c;  // constant_a
  localparam logic [7:0] OFF_CONSTB = 8'h10;  // constant_b
  localparam logic [7:0] OFF_COUNT  = 8'h14;  // timer_count
  localparam logic [7:0] OFF_ICLR   = 8'h18;  // irq_clear, write-only

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'he2;
  localparam logic [3:0] RST_OSEL  = 4'h0;
  localparam logic [7:0] RST_CONST = 8'hff;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] CNT_MAX   = 8'hff;

  // ----------------------------------------------------------------------
  // Field positions (flags and their enables share bits 7:5)
  // ----------------------------------------------------------------------
  localparam int FLAG_LSB    = 5;  // bit 5 wrap, 6 match A, 7 match B
  localparam int FLAG_WRAP   = 0;
  localparam int FLAG_A      = 1;
  localparam int FLAG_B      = 2;
  localparam int CLR_LSB     = 3;  // control_reg_zero 4:3
  localparam int CKS_LSB     = 0;  // control_reg_zero 2:0
  localparam int TEDGE_LSB   = 3;  // control_reg_one 4:3
  localparam int TRIGGER_ENABLE_BIT    = 2;
  localparam int ICKS_BIT    = 0;
  localparam logic [2:0] CTRL1_ONES = 3'h7;  // reserved bits read as 1
  localparam logic       CSR_ONE    = 1'h1;  // reserved csr bit 4

  // ----------------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_EXT  = 2'h3;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] CKS_DIV_LO  = 3'h1;
  localparam logic [2:0] CKS_DIV_MID = 3'h2;
  localparam logic [2:0] CKS_DIV_HI  = 3'h3;
  localparam logic [2:0] CKS_EXT_R   = 3'h5;
  localparam logic [2:0] CKS_EXT_F   = 3'h6;
  localparam logic [2:0] CKS_EXT_B   = 3'h7;
  localparam int PRESC_W = 7;  // largest divide is 128

  // Output actions, encoded so that a larger code wins a conflict
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_ZERO = 2'h1;
  localparam logic [1:0] ACT_ONE  = 2'h2;
  localparam logic [1:0] ACT_TOG  = 2'h3;

endpackage

// [src/ect_timer.sv]
/*
  Eight-bit up-counter with two compare constants, one waveform output,
  trigger start/stop and external clear, reached over APB.
  Assumes pins are synchronous to pclk and power_down is high in every
  low-power mode in which the timer must stay in reset.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ect_timer
  import ect_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_down,
  input  wire logic        ext_clock_input,
  input  wire logic        trigger_input,
  input  wire logic        external_clear_input,
  output logic             waveform_output,
  output logic             timer_irq
);

  // Conflicting actions resolve to the larger code
  function automatic logic [1:0] pick_action(input logic [1:0] a, input logic [1:0] b);
    pick_action = (a > b) ? a : b;
  endfunction

  logic [7:0]  ctrl0_q;
  logic [4:0]  ctrl1_q;
  logic [3:0]  osel_q;
  logic [7:0]  const_a_q;
  logic [7:0]  const_b_q;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic        running_q;
  logic        running_d;
  logic        trig_prev_q;
  logic        xclr_prev_q;
  logic        wave_d;
  logic [31:0] prdata_d;
  logic [2:0]  flags_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire hit      = (paddr == OFF_CTRL0) | (paddr == OFF_CTRL1) | (paddr == OFF_CSR) |
                  (paddr == OFF_CONSTA) | (paddr == OFF_CONSTB) | (paddr == OFF_COUNT) |
                  (paddr == OFF_ICLR);
  wire wr_ctrl0 = wr & (paddr == OFF_CTRL0);
  wire wr_ctrl1 = wr & (paddr == OFF_CTRL1);
  wire wr_csr   = wr & (paddr == OFF_CSR);
  wire wr_ca    = wr & (paddr == OFF_CONSTA);
  wire wr_cb    = wr & (paddr == OFF_CONSTB);
  wire wr_cnt   = wr & (paddr == OFF_COUNT);
  wire wr_iclr  = wr & (paddr == OFF_ICLR);
  assign pready  = access;
  assign pslverr = access & ~hit;

  // ----------------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------------
  wire [2:0] irq_en     = ctrl0_q[FLAG_LSB +: 3];
  wire [1:0] clr_sel    = ctrl0_q[CLR_LSB +: 2];
  wire [2:0] clk_sel    = ctrl0_q[CKS_LSB +: 3];
  wire [1:0] trig_edge  = ctrl1_q[TEDGE_LSB +: 2];
  wire       trig_en    = ctrl1_q[TRIGGER_ENABLE_BIT];
  wire       int_clksel = ctrl1_q[ICKS_BIT];
  wire [1:0] act_a      = osel_q[1:0];
  wire [1:0] act_b      = osel_q[3:2];

  // ----------------------------------------------------------------------
  // Counting clock
  // ----------------------------------------------------------------------
  logic tick;
  ect_clkgen u_clkgen (
    .pclk                  (pclk),
    .presetn               (presetn),
    .hold                  (power_down),
    .clock_select          (clk_sel),
    .internal_clock_select (int_clksel),
    .ext_clock_input       (ext_clock_input),
    .tick                  (tick)
  );

  // ----------------------------------------------------------------------
  // Trigger and external clear edges
  // ----------------------------------------------------------------------
  wire trig_rise = trigger_input & ~trig_prev_q;
  wire trig_fall = ~trigger_input & trig_prev_q;
  // Falling edge selected by field value 10
  wire trig_hit  = ((trig_edge == EDGE_RISE) & trig_rise) | ((trig_edge == EDGE_FALL) & trig_fall) |
                   ((trig_edge == EDGE_BOTH) & (trig_rise | trig_fall));
  wire xclr_rise = external_clear_input & ~xclr_prev_q;

  // Counting allowed unless the trigger function has halted it
  wire tick_eff  = tick & (~trig_en | running_q);

  // ----------------------------------------------------------------------
  // Compare and clear events
  // ----------------------------------------------------------------------
  // Match fires on the tick that moves the counter off the constant
  wire match_a   = tick_eff & (count_q == const_a_q) & ~wr_ca;
  wire match_b   = tick_eff & (count_q == const_b_q) & ~wr_cb;
  // Clear source by selection
  wire clear_evt = ((clr_sel == CLR_A) & match_a) | ((clr_sel == CLR_B) & match_b) |
                   ((clr_sel == CLR_EXT) & xclr_rise);
  wire wrap      = tick_eff & (count_q == CNT_MAX) & ~wr_cnt & ~clear_evt;

  // ----------------------------------------------------------------------
  // Counter next value: clear, then write, then increment
  // ----------------------------------------------------------------------
  assign count_d = clear_evt ? RST_COUNT :
                   wr_cnt    ? pwdata[7:0] :
                   tick_eff  ? count_q + 8'h01 :
                   count_q;

  // Trigger mode: arming write or clear halts; selected edge restarts
  assign running_d = (wr_ctrl1 & pwdata[TRIGGER_ENABLE_BIT] & ~trig_en) ? 1'b0 :
                     (trig_en & clear_evt) ? 1'b0 :
                     (trig_en & trig_hit)  ? 1'b1 :
                     running_q;

  // ----------------------------------------------------------------------
  // Waveform output: A and B actions merged by priority
  // ----------------------------------------------------------------------
  wire [1:0] act_now = pick_action(match_a ? act_a : ACT_NONE, match_b ? act_b : ACT_NONE);
  // With 0110, A drives high and B drives low: period A, width B
  assign wave_d = (act_now == ACT_TOG)  ? ~waveform_output :
                  (act_now == ACT_ONE)  ? 1'b1 :
                  (act_now == ACT_ZERO) ? 1'b0 :
                  waveform_output;

  // ----------------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------------
  wire [2:0] ev_set = {match_b, match_a, wrap};
  wire [2:0] ev_clr = wr_iclr ? pwdata[FLAG_LSB +: 3] : 3'h0;
  ect_irq #(.N(3)) u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (power_down),
    .set_ev  (ev_set),
    .clr_ev  (ev_clr),
    .enable  (irq_en),
    .flags_q (flags_q),
    .irq     (timer_irq)
  );

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  assign prdata_d = (paddr == OFF_CTRL0)  ? {24'h0, ctrl0_q} :
                    (paddr == OFF_CTRL1)  ? {24'h0, CTRL1_ONES, ctrl1_q[4:2], 1'b1, ctrl1_q[0]} :
                    (paddr == OFF_CSR)    ? {24'h0, flags_q, CSR_ONE, osel_q} :
                    (paddr == OFF_CONSTA) ? {24'h0, const_a_q} :
                    (paddr == OFF_CONSTB) ? {24'h0, const_b_q} :
                    (paddr == OFF_COUNT)  ? {24'h0, count_q} :
                    32'h0;

  // ----------------------------------------------------------------------
  // Registers; low-power modes hold everything at reset
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q         <= RST_CTRL0;
      ctrl1_q         <= RST_CTRL1[4:0];
      osel_q          <= RST_OSEL;
      const_a_q       <= RST_CONST;
      const_b_q       <= RST_CONST;
      count_q         <= RST_COUNT;
      running_q       <= 1'b0;
      waveform_output <= 1'b0;
    end else if (power_down) begin
      ctrl0_q         <= RST_CTRL0;
      ctrl1_q         <= RST_CTRL1[4:0];
      osel_q          <= RST_OSEL;
      const_a_q       <= RST_CONST;
      const_b_q       <= RST_CONST;
      count_q         <= RST_COUNT;
      running_q       <= 1'b0;
      waveform_output <= 1'b0;
    end else begin
      if (wr_ctrl0) ctrl0_q <= pwdata[7:0];
      if (wr_ctrl1) ctrl1_q <= {pwdata[4:2], 1'b1, pwdata[0]};
      if (wr_csr) osel_q <= pwdata[3:0];
      if (wr_ca) const_a_q <= pwdata[7:0];
      if (wr_cb) const_b_q <= pwdata[7:0];
      count_q         <= count_d;
      running_q       <= running_d;
      waveform_output <= wave_d;
    end
  end

  // Pin history and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= 1'b0;
      xclr_prev_q <= 1'b0;
      prdata      <= 32'h0;
    end else begin
      trig_prev_q <= trigger_input;
      xclr_prev_q <= external_clear_input;
      if (psel & ~penable) prdata <= prdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_power_hold: assert property (@(posedge pclk) disable iff (!presetn)
    power_down |=> (count_q == RST_COUNT && const_a_q == RST_CONST && !waveform_output))
    else $error("low-power mode did not reset timer");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_en == 3'h0) |-> !timer_irq)
    else $error("request raised while all enables off");
  a_clear_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (clear_evt && wr_cnt && !power_down) |=> (count_q == RST_COUNT))
    else $error("counter write beat clear");
  a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cnt && !clear_evt && !power_down) |=> (count_q == $past(pwdata[7:0])))
    else $error("counter write lost");
  a_match_mask: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ca |-> !match_a)
    else $error("match A fired during constant write");
  a_match_time: assert property (@(posedge pclk) disable iff (!presetn)
    (match_b && !power_down) |=> (flags_q[FLAG_B] && $past(count_q) == $past(const_b_q)))
    else $error("match B timing wrong");
  a_set_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (osel_q == 4'h6 && match_a && !match_b && !power_down) |=> waveform_output)
    else $error("output not driven high on match A");
  a_toggle_prio: assert property (@(posedge pclk) disable iff (!presetn)
    (act_now == ACT_TOG && !power_down) |=> (waveform_output != $past(waveform_output)))
    else $error("toggle did not win");
  a_trig_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (trig_en && clear_evt && !power_down) |=> (!running_q && count_q == RST_COUNT))
    else $error("trigger mode did not halt on clear");
  a_ext_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_sel == CLR_EXT && xclr_rise && !power_down) |=> (count_q == RST_COUNT))
    else $error("external clear ignored");
  a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (wrap && !power_down) |=> (count_q == 8'h00 && flags_q[FLAG_WRAP]))
    else $error("wrap not flagged");

  // Clear selection, counting steps, trigger start, match B masking and output actions
  a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_sel == CLR_A && match_a && !power_down) |=> (count_q == RST_COUNT))
    else $error("match A did not clear counter");
  a_clear_on_b: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_sel == CLR_B && match_b && !power_down) |=> (count_q == RST_COUNT))
    else $error("match B did not clear counter");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_eff && !clear_evt && !wr_cnt && !power_down) |=> (count_q == $past(count_q) + 8'h01))
    else $error("tick did not add one");
  a_halted_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (trig_en && !running_q && !wr_cnt && !clear_evt && !power_down) |=> (count_q == $past(count_q)))
    else $error("halted counter moved");
  a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
    (trig_en && trig_edge == EDGE_FALL && trig_fall && !clear_evt && !wr_ctrl1 && !power_down) |=> running_q)
    else $error("falling trigger did not start counter");
  a_reset_low: assert property (@(posedge pclk) disable iff (!presetn)
    (osel_q == 4'h6 && match_b && !match_a && !power_down) |=> !waveform_output)
    else $error("output not driven low on match B");
  a_match_b_mask: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cb |-> !match_b)
    else $error("match B fired during constant write");
  a_no_action: assert property (@(posedge pclk) disable iff (!presetn)
    (act_now == ACT_NONE && !power_down) |=> (waveform_output == $past(waveform_output)))
    else $error("output moved without an action");

endmodule
`default_nettype wire

// [test/ect_pins.sv]
/*
  Far-side pin model: drives the trigger, clear and external clock pins and
  measures the waveform output. Assumes pins are synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ect_pins (
  input  wire logic pclk,
  input  wire logic waveform_output,
  output logic      trigger_input,
  output logic      external_clear_input,
  output logic      ext_clock_input
);
  logic wf_q = 1'h0;
  int   since = 0;
  int   period = 0;
  int   width = 0;

  // Idle levels of the pins
  initial begin
    trigger_input = 1'h1;
    external_clear_input = 1'h0;
    ext_clock_input = 1'h0;
  end

  // Cycles from rise to rise, and from rise to fall
  always @(posedge pclk) begin
    wf_q <= waveform_output;
    since <= since + 1;
    if (waveform_output && !wf_q) begin
      period <= since;
      since <= 1;
    end
    if (!waveform_output && wf_q) width <= since;
  end

  // Falling edge on the trigger pin, held three clocks
  task automatic trig_fall();
    @(posedge pclk);
    trigger_input <= 1'h0;
    repeat (3) @(posedge pclk);
    trigger_input <= 1'h1;
  endtask

  // Rising pulse on the clear pin, held three clocks
  task automatic clr_rise();
    @(posedge pclk);
    external_clear_input <= 1'h1;
    repeat (3) @(posedge pclk);
    external_clear_input <= 1'h0;
  endtask

  // External clock pulses, two clocks high and two low, then a final level
  task automatic ext_pulses(input int n, input logic last);
    repeat (n) begin
      @(posedge pclk);
      ext_clock_input <= 1'h1;
      repeat (2) @(posedge pclk);
      ext_clock_input <= 1'h0;
      @(posedge pclk);
    end
    @(posedge pclk);
    ext_clock_input <= last;
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
/*
  Self-checking bench for the compare timer: APB tasks, pin model, tests.
  Assumes the design answers APB accesses with pready in the access cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench import ect_pkg::*;;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        power_down = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trigger_input;
  logic        external_clear_input;
  logic        ext_clock_input;
  logic        waveform_output;
  logic        timer_irq;
  logic [31:0] rd_q;
  logic        err_q;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  ect_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down(power_down), .ext_clock_input(ext_clock_input), .trigger_input(trigger_input),
    .external_clear_input(external_clear_input), .waveform_output(waveform_output),
    .timer_irq(timer_irq));
  ect_pins pins (.pclk(pclk), .waveform_output(waveform_output), .trigger_input(trigger_input),
    .external_clear_input(external_clear_input), .ext_clock_input(ext_clock_input));

  // 10 MHz clock and a cycle ceiling against hangs
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    apb(1'h0, a, 8'h00);
    chk(nm, {24'h0, exp}, rd_q);
  endtask
  task automatic irq_is(input logic exp);
    @(negedge pclk);
    chk("timer_irq", {31'h0, exp}, {31'h0, timer_irq});
  endtask
  task automatic rst_vals(input string nm);
    rdc(OFF_CTRL0, RST_CTRL0, "ctrl0");
    rdc(OFF_CTRL1, RST_CTRL1, "ctrl1");
    rdc(OFF_CSR, 8'h10, "csr");
    rdc(OFF_CONSTA, RST_CONST, "const_a");
    rdc(OFF_CONSTB, RST_CONST, "const_b");
    rdc(OFF_COUNT, RST_COUNT, "count");
    chk("waveform", 32'h0, {31'h0, waveform_output});
    $display("test %s done", nm);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rst_vals("reset");
    rdc(OFF_ICLR, 8'h00, "irq_clear read");
    apb(1'h0, 8'h1c, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, err_q});
    // Repeating pulse: clear on A, one at A, zero at B
    wr(OFF_CONSTA, 8'h03);
    wr(OFF_CONSTB, 8'h01);
    wr(OFF_CSR, 8'h06);
    wr(OFF_CTRL0, 8'h49);
    repeat (80) @(posedge pclk);
    chk("period", 32'h10, pins.period);
    chk("width", 32'h08, pins.width);
    rdc(OFF_CSR, 8'hd6, "match flags");
    irq_is(1'h1);
    wr(OFF_CTRL0, 8'h89);
    irq_is(1'h1);
    wr(OFF_CTRL0, 8'h09);
    irq_is(1'h0);
    $display("test pulse done");
    // Simultaneous matches: toggle beats zero
    wr(OFF_CONSTB, 8'h03);
    wr(OFF_CSR, 8'h07);
    repeat (130) @(posedge pclk);
    chk("toggle period", 32'h20, pins.period);
    chk("toggle width", 32'h10, pins.width);
    $display("test priority done");
    // Wrap flag and flag clearing
    wr(OFF_CTRL0, 8'h20);
    wr(OFF_ICLR, 8'he0);
    rdc(OFF_CSR, 8'h17, "flags cleared");
    wr(OFF_COUNT, 8'hfe);
    rdc(OFF_COUNT, 8'hfe, "count write");
    wr(OFF_CTRL0, 8'h21);
    repeat (12) @(posedge pclk);
    rdc(OFF_CSR, 8'h37, "wrap flag");
    irq_is(1'h1);
    $display("test wrap done");
    // Low-power mode returns every register to reset
    @(posedge pclk);
    power_down <= 1'h1;
    repeat (2) @(posedge pclk);
    power_down <= 1'h0;
    rst_vals("power down");
    // Single shot from a falling trigger edge
    wr(OFF_CONSTA, 8'h02);
    wr(OFF_CONSTB, 8'h05);
    wr(OFF_CSR, 8'h06);
    wr(OFF_CTRL1, 8'h14);
    rdc(OFF_CTRL1, 8'hf6, "trigger setup");
    wr(OFF_CTRL0, 8'h11);
    repeat (20) @(posedge pclk);
    rdc(OFF_COUNT, 8'h00, "halted");
    pins.trig_fall();
    repeat (60) @(posedge pclk);
    chk("shot width", 32'h0c, pins.width);
    rdc(OFF_COUNT, 8'h00, "halted again");
    $display("test single shot done");
    // External clear pin
    wr(OFF_CTRL1, 8'h00);
    wr(OFF_CTRL0, 8'h18);
    wr(OFF_COUNT, 8'h5a);
    rdc(OFF_COUNT, 8'h5a, "count held");
    pins.clr_rise();
    rdc(OFF_COUNT, 8'h00, "external clear");
    $display("test external clear done");
    // Contention: clear against write, write against increment
    fork
      wr(OFF_COUNT, 8'h77);
      begin
        @(posedge pclk);
        pins.clr_rise();
      end
    join
    rdc(OFF_COUNT, 8'h00, "clear beats write");
    wr(OFF_CTRL0, 8'h06);
    pins.ext_pulses(3, 1'h0);
    rdc(OFF_COUNT, 8'h03, "external edges");
    fork
      pins.ext_pulses(1, 1'h1);
      begin
        @(posedge pclk);
        wr(OFF_COUNT, 8'h40);
      end
    join
    rdc(OFF_COUNT, 8'h40, "write beats increment");
    // Leaving a high external level for the stopped source counts once
    wr(OFF_CTRL0, 8'h00);
    rdc(OFF_COUNT, 8'h41, "source switch count");
    // Constant write in the matching cycle hides the match
    wr(OFF_ICLR, 8'he0);
    wr(OFF_CONSTA, 8'h41);
    wr(OFF_CTRL0, 8'h06);
    fork
      pins.ext_pulses(1, 1'h0);
      begin
        @(posedge pclk);
        wr(OFF_CONSTA, 8'h41);
      end
    join
    rdc(OFF_CSR, 8'h16, "match masked");
    $display("test contention done");
    end_of_test();
  end
endmodule
`default_nettype wire
